// ===== dv/mctw_core_model.sv
// Processor core model: register accesses and instruction pulses
`timescale 1ns/10ps
module mctw_core_model
    import mctw_pkg::*;
(
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    output logic [3:0] addr_out,
    output logic page_out,
    output logic wr_out,
    output logic [7:0] wdata_out,
    output mctw_instr_s instr_out
);
    initial begin
        addr_out = 4'h0;
        page_out = 1'b0;
        wr_out = 1'b0;
        wdata_out = 8'h00;
        instr_out = '0;
    end
    // Read data is registered, so it is taken one cycle after the address
    task automatic access(input logic p, input logic [3:0] a, input logic w,
        input logic [7:0] d, output logic [7:0] q);
        @(negedge clk_in);
        page_out = p;
        addr_out = a;
        wr_out = w;
        wdata_out = d;
        @(negedge clk_in);
        wr_out = 1'b0;
        wdata_out = ~d;
        q = rdata_in;
    endtask
    task automatic pulse(input logic [5:0] p);
        @(negedge clk_in);
        instr_out = p;
        @(negedge clk_in);
        instr_out = '0;
    endtask
endmodule // mctw_core_model

// ===== dv/mctw_regs_tb.sv
// Self-checking bench for the control register block
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %0t got %h exp %h", $time, g, e); end end
module mctw_regs_tb;
    import mctw_pkg::*;
    logic clk_in = 0, rst_n_in = 0, osc = 0, opt = 0, tpin = 0, xpin = 1, chg = 0, tick = 0;
    logic pg, wr, irq, gie, wdr, ick;
    logic [3:0] addr;
    logic [7:0] wd, rd, q, d;
    logic [2:0] fl;
    mctw_instr_s ins;
    mctw_pincfg_s pc;
    int num_errors = 0, n_tests = 0, cyc = 0, wdr_cnt = 0, nick = 0, m;
    logic [3:0] ra[8] = '{4'h1, 4'h5, 4'h6, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
    logic [7:0] rv[8] = '{8'hBF, 8'h0F, 8'hFF, 8'h77, 8'h00, 8'hF7, 8'h80, 8'h00};
    logic [7:0] rm[8] = '{8'h7F, 8'h0F, 8'hFF, 8'h77, 8'hF7, 8'hF7, 8'hC0, 8'h07};
    mctw_regs #(.WDT_TICKS(4)) i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .osc_clk_in(osc),
        .clk_option_in(opt), .reg_addr_in(addr), .reg_ctrl_page_in(pg), .reg_wr_in(wr),
        .reg_wdata_in(wd), .instr_in(ins), .timer_input_pin_in(tpin), .ext_irq_pin_in(xpin),
        .port_change_in(chg), .wdt_tick_in(tick), .instr_clk_out(ick), .reg_rdata_out(rd),
        .pincfg_out(pc), .interrupt_flags_out(fl), .global_irq_enable_out(gie),
        .irq_request_out(irq), .wdt_reset_out(wdr));
    mctw_core_model i_core (.clk_in(clk_in), .rdata_in(rd), .addr_out(addr), .page_out(pg),
        .wr_out(wr), .wdata_out(wd), .instr_out(ins));
    always #5 clk_in = ~clk_in;
    always #2.5 osc = ~osc;
    // Reset pulse is sampled away from the edge that launches it
    always @(negedge clk_in) if (wdr === 1'b1) wdr_cnt <= wdr_cnt + 1;
    always @(posedge ick) nick <= nick + 1;
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic wrr(input logic p, input logic [3:0] a, input logic [7:0] v);
        i_core.access(p, a, 1'b1, v, q);
    endtask
    task automatic rdc(input logic p, input logic [3:0] a, input logic [7:0] e);
        i_core.access(p, a, 1'b0, 8'h00, q);
        `CHK(q, e)
    endtask
    // Watchdog oscillator edges, slow against the instruction clock
    task automatic ticks(input int k);
        repeat (k) begin
            tick = 1'b1;
            repeat (5) @(negedge clk_in);
            tick = 1'b0;
            repeat (5) @(negedge clk_in);
        end
    endtask
    task automatic summarize();
        $display("tests %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        void'($urandom(92));
        repeat (16) @(negedge clk_in);
        rst_n_in = 1'b1;
        for (int i = 0; i < 8; i++) rdc(1'b1, ra[i], rv[i]);
        rdc(1'b1, 4'h2, 8'h00);
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            wrr(1'b1, ra[i], d);
            rdc(1'b1, ra[i], d & rm[i]);
        end
        wrr(1'b1, 4'h5, 8'hF6);
        wrr(1'b1, 4'hC, 8'h5D);
        `CHK(pc.port_a_drive_en_n, 8'h06)
        `CHK(pc.opendrain_en, 8'h55)
        wrr(1'b1, 4'h6, 8'h5A);
        wrr(1'b1, 4'hB, 8'h35);
        wrr(1'b1, 4'hD, 8'hA6);
        `CHK(pc.port_b_drive_en_n, 8'h5A)
        `CHK(pc.pulldown_en, 6'b100010)
        `CHK(pc.pullup_en & 8'hF7, 8'h51)
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            i_core.pulse(i[0] ? (i[1] ? 6'h08 : 6'h20) : (i[1] ? 6'h10 : 6'h01));
            `CHK(gie, i[0])
        end
        wrr(1'b1, 4'hF, 8'h01);
        wrr(1'b1, 4'h1, 8'h48);
        wrr(1'b0, 4'h1, 8'hFF);
        rdc(1'b0, 4'hF, 8'h01);
        `CHK(irq, 1'b1)
        wrr(1'b0, 4'hF, 8'h00);
        wrr(1'b0, 4'hF, 8'hFF);
        rdc(1'b0, 4'hF, 8'h00);
        for (int n = 0; n < 8; n++) begin
            wrr(1'b1, 4'h1, 8'(n));
            `CHK(pc.timer_pin_is_port, 1'b1)
            wrr(1'b0, 4'h1, 8'h00);
            repeat ((2 << n) * 4 - 2) @(negedge clk_in);
            i_core.access(1'b0, 4'h1, 1'b0, 8'h00, q);
            `CHK(q, 8'h03)
        end
        for (int e = 0; e < 2; e++) begin
            tpin = 1'b0;
            wrr(1'b1, 4'h1, 8'h28 | 8'(e << 4));
            `CHK(pc.timer_pin_is_port, 1'b0)
            wrr(1'b0, 4'h1, 8'h00);
            for (int k = 0; k < 5; k++) begin
                repeat (4) @(negedge clk_in);
                tpin = ~tpin;
            end
            repeat (4) @(negedge clk_in);
            rdc(1'b0, 4'h1, 8'(3 - e));
        end
        wrr(1'b1, 4'h6, 8'hFF);
        wrr(1'b1, 4'hF, 8'h04);
        for (int s = 1; s >= 0; s--) begin
            wrr(1'b1, 4'hE, 8'(s << 6));
            `CHK(pc.ext_irq_pin_select, s[0])
            wrr(1'b0, 4'hF, 8'h00);
            xpin = 1'b0;
            repeat (4) @(negedge clk_in);
            xpin = 1'b1;
            rdc(1'b0, 4'hF, 8'(s << 2));
        end
        wrr(1'b1, 4'hF, 8'h02);
        wrr(1'b0, 4'hF, 8'h00);
        chg = 1'b1;
        repeat (4) @(negedge clk_in);
        chg = 1'b0;
        rdc(1'b0, 4'hF, 8'h02);
        `CHK(fl[MCTW_IRQ_CHG_BIT], 1'b1)
        // Instruction clock is osc/2 or osc/4; count its edges over ten cycles
        for (int o = 0; o < 2; o++) begin
            opt = o[0];
            repeat (2) @(negedge clk_in);
            m = nick;
            repeat (10) @(negedge clk_in);
            `CHK(nick - m, 10 >> o)
        end
        $display("test timer done");
        wrr(1'b1, 4'h1, 8'h08);
        for (int s = 1; s >= 0; s--) begin
            wrr(1'b1, 4'hE, 8'(s << 7));
            m = wdr_cnt;
            ticks(3);
            i_core.pulse(s[0] ? 6'h04 : 6'h02);
            ticks(3);
            `CHK(wdr_cnt - m, 0)
            ticks(2);
            `CHK(wdr_cnt - m, s)
        end
        $display("test watchdog done");
        summarize();
    end
endmodule // mctw_regs_tb

// ===== hdl/mctw_regs.sv
// Control registers, shared prescaler, timer and watchdog of the controller core
`timescale 1ns/10ps
module mctw_regs
    import mctw_pkg::*;
#(
    parameter int WDT_TICKS = MCTW_WDT_TICKS
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic osc_clk_in,
    input wire logic clk_option_in,
    input wire logic [3:0] reg_addr_in,
    input wire logic reg_ctrl_page_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire mctw_instr_s instr_in,
    input wire logic timer_input_pin_in,
    input wire logic ext_irq_pin_in,
    input wire logic port_change_in,
    input wire logic wdt_tick_in,
    output logic instr_clk_out,
    output logic [7:0] reg_rdata_out,
    output mctw_pincfg_s pincfg_out,
    output logic [2:0] interrupt_flags_out,
    output logic global_irq_enable_out,
    output logic irq_request_out,
    output logic wdt_reset_out
);
    logic [7:0] timer_control_reg, timer_control_next;
    logic [7:0] port_a_direction_reg, port_a_direction_next;
    logic [7:0] port_b_direction_reg, port_b_direction_next;
    logic [7:0] pulldown_control_reg, pulldown_control_next;
    logic [7:0] opendrain_control_reg, opendrain_control_next;
    logic [7:0] pullup_control_reg, pullup_control_next;
    logic [7:0] watchdog_control_reg, watchdog_control_next;
    logic [7:0] interrupt_mask_reg, interrupt_mask_next;
    logic [7:0] timer_counter_reg, timer_counter_next;
    logic [7:0] prescaler_reg, prescaler_next;
    logic [2:0] irq_flags_reg, irq_flags_next;
    logic [31:0] wdt_count_reg, wdt_count_next;
    logic wdt_reset_reg, wdt_reset_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [1:0] div_reg, div_next;
    logic [2:0] tpin_sync_reg, epin_sync_reg, tick_sync_reg;
    logic [1:0] chg_sync_reg;

    function automatic logic ctrl_hit(input logic [3:0] a, input logic [3:0] target,
                                      input logic page, input logic wr);
        ctrl_hit = wr && page && (a == target);
    endfunction

    function automatic logic data_hit(input logic [3:0] a, input logic [3:0] target,
                                      input logic page, input logic wr);
        data_hit = wr && !page && (a == target);
    endfunction

    // Divide-by-2^k tap of the prescaler: 1 when the low k bits wrap to zero
    function automatic logic ratio_tick(input logic [7:0] cnt, input logic [3:0] k);
        logic [7:0] msk;
        msk = 8'h00;
        msk = 8'((16'h0001 << k) - 16'h0001);
        ratio_tick = ((cnt & msk) == msk);
    endfunction

    // Instruction-cycle clock divided down from the oscillator
    always_comb begin
        div_next = div_reg + 2'h1;
        if (div_reg >= (clk_option_in ? MCTW_CLK_DIV_SLOW : MCTW_CLK_DIV_FAST)) begin
            div_next = 2'h0;
        end
    end

    always_ff @(posedge osc_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_next;
        end
    end
    assign instr_clk_out = clk_option_in ? div_reg[1] : div_reg[0];

    // Pin and watchdog-tick synchronisers; first stage feeds only the second
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tpin_sync_reg <= 3'h0;
            epin_sync_reg <= 3'h7;
            tick_sync_reg <= 3'h0;
            chg_sync_reg <= 2'h0;
        end else begin
            tpin_sync_reg <= {tpin_sync_reg[1:0], timer_input_pin_in};
            epin_sync_reg <= {epin_sync_reg[1:0], ext_irq_pin_in};
            tick_sync_reg <= {tick_sync_reg[1:0], wdt_tick_in};
            chg_sync_reg <= {chg_sync_reg[0], port_change_in};
        end
    end

    logic tpin_rise, tpin_fall, ext_fall, wdt_tick, psa_wdt, timer_write, timer_step;
    logic pre_src, pre_tick, wdt_clear, timer_ovf;
    logic [2:0] ratio;
    assign tpin_rise = tpin_sync_reg[1] && !tpin_sync_reg[2];
    assign tpin_fall = !tpin_sync_reg[1] && tpin_sync_reg[2];
    assign ext_fall = !epin_sync_reg[1] && epin_sync_reg[2];
    assign wdt_tick = tick_sync_reg[1] && !tick_sync_reg[2];
    assign psa_wdt = timer_control_reg[MCTW_TC_PSA_BIT];
    assign ratio = timer_control_reg[MCTW_TC_PSR_LSB +: 3];
    assign timer_write = data_hit(reg_addr_in, MCTW_ADDR_TIMER_COUNTER,
                                  reg_ctrl_page_in, reg_wr_in);
    assign wdt_clear = instr_in.watchdog_clear_instr || instr_in.sleep_instr;

    // Timer source event before the prescaler
    logic timer_src;
    always_comb begin
        if (timer_control_reg[MCTW_TC_SRC_BIT]) begin
            timer_src = timer_control_reg[MCTW_TC_EDGE_BIT] ? tpin_fall : tpin_rise;
        end else begin
            timer_src = 1'b1;
        end
    end

    // Shared prescaler and its divided output
    always_comb begin
        pre_src = psa_wdt ? wdt_tick : timer_src;
        pre_tick = 1'b0;
        prescaler_next = prescaler_reg;
        if (pre_src) begin
            prescaler_next = prescaler_reg + 8'h01;
            pre_tick = psa_wdt ? ratio_tick(prescaler_reg, {1'b0, ratio})
                               : ratio_tick(prescaler_reg, {1'b0, ratio} + 4'h1);
        end
        if ((!psa_wdt && timer_write) || (psa_wdt && wdt_clear)) begin
            prescaler_next = 8'h00;
        end
    end

    // Timer counter
    always_comb begin
        timer_step = psa_wdt ? timer_src : pre_tick;
        timer_counter_next = timer_counter_reg;
        timer_ovf = 1'b0;
        if (timer_write) begin
            timer_counter_next = reg_wdata_in;
        end else if (timer_step) begin
            timer_counter_next = timer_counter_reg + 8'h01;
            timer_ovf = (timer_counter_reg == 8'hFF);
        end
    end

    // Watchdog on its own tick, or on the prescaler output when psa_wdt is set; timeout pulses the device reset request
    always_comb begin
        logic step;
        step = 1'b0;
        step = psa_wdt ? pre_tick : wdt_tick;
        wdt_count_next = wdt_count_reg;
        wdt_reset_next = 1'b0;
        if (wdt_clear || !watchdog_control_reg[MCTW_WC_WDE_BIT]) begin
            wdt_count_next = 32'h0;
        end else if (step) begin
            if (wdt_count_reg >= 32'(WDT_TICKS - 1)) begin
                wdt_count_next = 32'h0;
                wdt_reset_next = 1'b1;
            end else begin
                wdt_count_next = wdt_count_reg + 32'h1;
            end
        end
    end

    // Register writes, instruction effects and interrupt flags
    always_comb begin
        logic cw;
        cw = reg_wr_in && reg_ctrl_page_in;
        timer_control_next = timer_control_reg;
        port_a_direction_next = port_a_direction_reg;
        port_b_direction_next = port_b_direction_reg;
        pulldown_control_next = pulldown_control_reg;
        opendrain_control_next = opendrain_control_reg;
        pullup_control_next = pullup_control_reg;
        watchdog_control_next = watchdog_control_reg;
        interrupt_mask_next = interrupt_mask_reg;
        irq_flags_next = irq_flags_reg;
        if (cw && reg_addr_in == MCTW_ADDR_TIMER_CONTROL) begin
            timer_control_next = reg_wdata_in & MCTW_MASK_TIMER_CONTROL;
        end
        if (instr_in.disable_irq_instr || instr_in.irq_taken) begin
            timer_control_next[MCTW_TC_GIE_BIT] = 1'b0;
        end else if (instr_in.enable_irq_instr || instr_in.return_from_irq_instr) begin
            timer_control_next[MCTW_TC_GIE_BIT] = 1'b1;
        end
        if (ctrl_hit(reg_addr_in, MCTW_ADDR_PORT_A_DIRECTION, reg_ctrl_page_in, reg_wr_in)) begin
            port_a_direction_next = reg_wdata_in & MCTW_MASK_PORT_A_DIRECTION;
        end
        if (ctrl_hit(reg_addr_in, MCTW_ADDR_PORT_B_DIRECTION, reg_ctrl_page_in, reg_wr_in)) begin
            port_b_direction_next = reg_wdata_in;
        end
        if (ctrl_hit(reg_addr_in, MCTW_ADDR_PULLDOWN_CONTROL, reg_ctrl_page_in, reg_wr_in)) begin
            pulldown_control_next = reg_wdata_in & MCTW_MASK_PULLDOWN_CONTROL;
        end
        if (ctrl_hit(reg_addr_in, MCTW_ADDR_OPENDRAIN_CONTROL, reg_ctrl_page_in, reg_wr_in)) begin
            opendrain_control_next = reg_wdata_in & MCTW_MASK_PORT_B_CFG;
        end
        if (ctrl_hit(reg_addr_in, MCTW_ADDR_PULLUP_CONTROL, reg_ctrl_page_in, reg_wr_in)) begin
            pullup_control_next = reg_wdata_in & MCTW_MASK_PORT_B_CFG;
        end
        if (ctrl_hit(reg_addr_in, MCTW_ADDR_WATCHDOG_CONTROL, reg_ctrl_page_in, reg_wr_in)) begin
            watchdog_control_next = reg_wdata_in & MCTW_MASK_WATCHDOG_CONTROL;
        end
        if (ctrl_hit(reg_addr_in, MCTW_ADDR_INTERRUPT_MASK, reg_ctrl_page_in, reg_wr_in)) begin
            interrupt_mask_next = reg_wdata_in & MCTW_MASK_IRQ;
        end
        // Software may only clear flags; a write of 1 keeps the old value
        if (data_hit(reg_addr_in, MCTW_ADDR_INTERRUPT_FLAGS, reg_ctrl_page_in, reg_wr_in)) begin
            irq_flags_next = irq_flags_reg & reg_wdata_in[2:0];
        end
        // Hardware set applied last so a same-cycle event beats the clear
        if (timer_ovf) begin
            irq_flags_next[MCTW_IRQ_TMR_BIT] = 1'b1;
        end
        if (chg_sync_reg[1]) begin
            irq_flags_next[MCTW_IRQ_CHG_BIT] = 1'b1;
        end
        if (ext_fall && watchdog_control_reg[MCTW_WC_EIS_BIT]) begin
            irq_flags_next[MCTW_IRQ_EXT_BIT] = 1'b1;
        end
    end

    // Read mux, registered so data leaves from flip-flops
    always_comb begin
        rdata_next = 8'h00;
        if (reg_ctrl_page_in) begin
            case (reg_addr_in)
                MCTW_ADDR_TIMER_CONTROL: rdata_next = timer_control_reg;
                MCTW_ADDR_PORT_A_DIRECTION: rdata_next = port_a_direction_reg;
                MCTW_ADDR_PORT_B_DIRECTION: rdata_next = port_b_direction_reg;
                MCTW_ADDR_PULLDOWN_CONTROL: rdata_next = pulldown_control_reg;
                MCTW_ADDR_OPENDRAIN_CONTROL: rdata_next = opendrain_control_reg;
                MCTW_ADDR_PULLUP_CONTROL: rdata_next = pullup_control_reg;
                MCTW_ADDR_WATCHDOG_CONTROL: rdata_next = watchdog_control_reg;
                MCTW_ADDR_INTERRUPT_MASK: rdata_next = interrupt_mask_reg;
                default: rdata_next = 8'h00;
            endcase
        end else begin
            case (reg_addr_in)
                MCTW_ADDR_TIMER_COUNTER: rdata_next = timer_counter_reg;
                MCTW_ADDR_INTERRUPT_FLAGS: rdata_next = {5'h00, irq_flags_reg} & interrupt_mask_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            timer_control_reg <= MCTW_RST_TIMER_CONTROL;
            port_a_direction_reg <= MCTW_RST_PORT_A_DIRECTION;
            port_b_direction_reg <= MCTW_RST_PORT_B_DIRECTION;
            pulldown_control_reg <= MCTW_RST_PULLDOWN_CONTROL & MCTW_MASK_PULLDOWN_CONTROL;
            opendrain_control_reg <= MCTW_RST_OPENDRAIN_CONTROL;
            pullup_control_reg <= MCTW_RST_PULLUP_CONTROL & MCTW_MASK_PORT_B_CFG;
            watchdog_control_reg <= MCTW_RST_WATCHDOG_CONTROL;
            interrupt_mask_reg <= MCTW_RST_INTERRUPT_MASK;
            timer_counter_reg <= 8'h00;
            prescaler_reg <= 8'h00;
            irq_flags_reg <= 3'h0;
            wdt_count_reg <= 32'h0;
            wdt_reset_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            timer_control_reg <= timer_control_next;
            port_a_direction_reg <= port_a_direction_next;
            port_b_direction_reg <= port_b_direction_next;
            pulldown_control_reg <= pulldown_control_next;
            opendrain_control_reg <= opendrain_control_next;
            pullup_control_reg <= pullup_control_next;
            watchdog_control_reg <= watchdog_control_next;
            interrupt_mask_reg <= interrupt_mask_next;
            timer_counter_reg <= timer_counter_next;
            prescaler_reg <= prescaler_next;
            irq_flags_reg <= irq_flags_next;
            wdt_count_reg <= wdt_count_next;
            wdt_reset_reg <= wdt_reset_next;
            rdata_reg <= rdata_next;
        end
    end

    // Pin configuration; enables are active-low where the bit means drive
    always_comb begin
        pincfg_out.port_a_drive_en_n = port_a_direction_reg;
        pincfg_out.port_b_drive_en_n = port_b_direction_reg;
        pincfg_out.pulldown_en = ~{pulldown_control_reg[6:4], pulldown_control_reg[2:0]};
        pincfg_out.opendrain_en = opendrain_control_reg;
        pincfg_out.pullup_en = ~pullup_control_reg & MCTW_MASK_PORT_B_CFG;
        pincfg_out.timer_pin_is_port = !timer_control_reg[MCTW_TC_SRC_BIT];
        pincfg_out.ext_irq_pin_select = watchdog_control_reg[MCTW_WC_EIS_BIT];
    end

    assign reg_rdata_out = rdata_reg;
    assign interrupt_flags_out = irq_flags_reg;
    assign global_irq_enable_out = timer_control_reg[MCTW_TC_GIE_BIT];
    assign irq_request_out = global_irq_enable_out
                             && |(irq_flags_reg & interrupt_mask_reg[2:0]);
    assign wdt_reset_out = wdt_reset_reg;

    property p_gie_clear;
        @(posedge clk_in) disable iff (!rst_n_in)
        (instr_in.disable_irq_instr || instr_in.irq_taken) |=> !global_irq_enable_out;
    endproperty
    a_gie_clear: assert property (p_gie_clear) else $error("irq enable not cleared");

    property p_gie_set;
        @(posedge clk_in) disable iff (!rst_n_in)
        (instr_in.enable_irq_instr && !instr_in.disable_irq_instr && !instr_in.irq_taken)
            |=> global_irq_enable_out;
    endproperty
    a_gie_set: assert property (p_gie_set) else $error("irq enable not set");

    property p_prescale_clr_timer;
        @(posedge clk_in) disable iff (!rst_n_in)
        (timer_write && !psa_wdt) |=> (prescaler_reg == 8'h00);
    endproperty
    a_prescale_clr_timer: assert property (p_prescale_clr_timer) else $error("prescaler kept");

    property p_wdt_clr;
        @(posedge clk_in) disable iff (!rst_n_in)
        (wdt_clear && psa_wdt) |=> (prescaler_reg == 8'h00 && wdt_count_reg == 32'h0);
    endproperty
    a_wdt_clr: assert property (p_wdt_clr) else $error("watchdog not cleared");

    property p_wdt_off;
        @(posedge clk_in) disable iff (!rst_n_in)
        !watchdog_control_reg[MCTW_WC_WDE_BIT] |=> !wdt_reset_out;
    endproperty
    a_wdt_off: assert property (p_wdt_off) else $error("disabled watchdog fired");

    property p_ovf_flag;
        @(posedge clk_in) disable iff (!rst_n_in)
        (timer_counter_reg == 8'hFF && timer_step && !timer_write)
            |=> (timer_counter_reg == 8'h00 && irq_flags_reg[MCTW_IRQ_TMR_BIT]);
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("overflow not flagged");

    property p_int_step;
        @(posedge clk_in) disable iff (!rst_n_in)
        (!timer_control_reg[MCTW_TC_SRC_BIT] && psa_wdt && !timer_write)
            |=> (timer_counter_reg == $past(timer_counter_reg) + 8'h01);
    endproperty
    a_int_step: assert property (p_int_step) else $error("timer missed a cycle");

    property p_flag_read;
        @(posedge clk_in) disable iff (!rst_n_in)
        (!reg_ctrl_page_in && reg_addr_in == MCTW_ADDR_INTERRUPT_FLAGS)
            |=> (reg_rdata_out == ({5'h00, $past(irq_flags_reg)} & $past(interrupt_mask_reg)));
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag read not masked");

    property p_porta_upper;
        @(posedge clk_in) disable iff (!rst_n_in)
        port_a_direction_reg[7:4] == 4'h0;
    endproperty
    a_porta_upper: assert property (p_porta_upper) else $error("port A upper bits set");
endmodule // mctw_regs

// ===== inc/mctw_pkg.sv
// Package: register map, field positions, reset values and timing counts for the control block
package mctw_pkg;
    // Control-page register addresses
    localparam logic [3:0] MCTW_ADDR_TIMER_CONTROL = 4'h1;
    localparam logic [3:0] MCTW_ADDR_PORT_A_DIRECTION = 4'h5;
    localparam logic [3:0] MCTW_ADDR_PORT_B_DIRECTION = 4'h6;
    localparam logic [3:0] MCTW_ADDR_PULLDOWN_CONTROL = 4'hB;
    localparam logic [3:0] MCTW_ADDR_OPENDRAIN_CONTROL = 4'hC;
    localparam logic [3:0] MCTW_ADDR_PULLUP_CONTROL = 4'hD;
    localparam logic [3:0] MCTW_ADDR_WATCHDOG_CONTROL = 4'hE;
    localparam logic [3:0] MCTW_ADDR_INTERRUPT_MASK = 4'hF;
    // Data-page addresses
    localparam logic [3:0] MCTW_ADDR_TIMER_COUNTER = 4'h1;
    localparam logic [3:0] MCTW_ADDR_INTERRUPT_FLAGS = 4'hF;

    // Timer control fields
    localparam int MCTW_TC_GIE_BIT = 6;
    localparam int MCTW_TC_SRC_BIT = 5;
    localparam int MCTW_TC_EDGE_BIT = 4;
    localparam int MCTW_TC_PSA_BIT = 3;
    localparam int MCTW_TC_PSR_LSB = 0;
    // Watchdog control fields
    localparam int MCTW_WC_WDE_BIT = 7;
    localparam int MCTW_WC_EIS_BIT = 6;
    // Interrupt mask / flag fields
    localparam int MCTW_IRQ_EXT_BIT = 2;
    localparam int MCTW_IRQ_CHG_BIT = 1;
    localparam int MCTW_IRQ_TMR_BIT = 0;

    // Reset values and implemented-bit masks
    localparam logic [7:0] MCTW_RST_TIMER_CONTROL = 8'hBF;
    localparam logic [7:0] MCTW_RST_PORT_A_DIRECTION = 8'h0F;
    localparam logic [7:0] MCTW_RST_PORT_B_DIRECTION = 8'hFF;
    localparam logic [7:0] MCTW_RST_PULLDOWN_CONTROL = 8'hFF;
    localparam logic [7:0] MCTW_RST_OPENDRAIN_CONTROL = 8'h00;
    localparam logic [7:0] MCTW_RST_PULLUP_CONTROL = 8'hFF;
    localparam logic [7:0] MCTW_RST_WATCHDOG_CONTROL = 8'h80;
    localparam logic [7:0] MCTW_RST_INTERRUPT_MASK = 8'h00;
    localparam logic [7:0] MCTW_MASK_TIMER_CONTROL = 8'h7F;
    localparam logic [7:0] MCTW_MASK_PORT_A_DIRECTION = 8'h0F;
    localparam logic [7:0] MCTW_MASK_PULLDOWN_CONTROL = 8'h77;
    localparam logic [7:0] MCTW_MASK_PORT_B_CFG = 8'hF7;
    localparam logic [7:0] MCTW_MASK_WATCHDOG_CONTROL = 8'hC0;
    localparam logic [7:0] MCTW_MASK_IRQ = 8'h07;

    // Watchdog timing: base period counted on the watchdog tick input
    localparam int MCTW_WDT_PERIOD_MS = 18;
    localparam int MCTW_WDT_TICK_US = 1000;
    localparam int MCTW_WDT_TICKS = (MCTW_WDT_PERIOD_MS * 1000) / MCTW_WDT_TICK_US;
    // Instruction-cycle divide by clock code option
    localparam logic [1:0] MCTW_CLK_DIV_FAST = 2'h1;
    localparam logic [1:0] MCTW_CLK_DIV_SLOW = 2'h3;

    // Instruction strobes from the core
    typedef struct packed {
        logic enable_irq_instr;
        logic disable_irq_instr;
        logic return_from_irq_instr;
        logic watchdog_clear_instr;
        logic sleep_instr;
        logic irq_taken;
    } mctw_instr_s;

    // Pin configuration to the port cells
    typedef struct packed {
        logic [7:0] port_a_drive_en_n;
        logic [7:0] port_b_drive_en_n;
        logic [5:0] pulldown_en;
        logic [7:0] opendrain_en;
        logic [7:0] pullup_en;
        logic timer_pin_is_port;
        logic ext_irq_pin_select;
    } mctw_pincfg_s;
endpackage : mctw_pkg
